// [design/redriver_config_control.sv]
// configuration and control of a four-lane re-driver: serial slave, strap capture,
// loopback, card present, standby and per-group receiver detect
// assumes SCL and SDA are sampled copies synchronous to CLK_IN; SDA is open drain
//
// What this block does
// RULE1: the slave address takes bits 0, 1 and 4 from three strap inputs.
// RULE2: with loop_back_n low, group A receive feeds both group A and group B transmit.
// RULE3: with loop_back_n high (pulled up) there is no loopback path.
// RULE4: with the source select low, serial writes change the configuration.
// RULE5: with the source select high, straps set the control register, the group registers hold and serial access is off.
// RULE6: at startup the strap levels are caught into the control register.
// RULE7: card_present_n low means a receiver exists and, with the bus enable high, enables all channels.
// RULE8: the bus enable input puts the device into low-power standby.
// RULE9: the source select is never latched; its present level gates serial access.
// RULE10: a group detect reset held low restarts that group's detect cycle.
// RULE11: detect runs only with card_present_n low; else termination goes weak.
// RULE12: writes arriving while straps are selected change no register.
`timescale 1ns/10ps
module redriver_config_control #(
  parameter logic [6:0] ADDR_BASE    = redriver_cfg_pkg::ADDR_BASE,
  parameter int         PROBE_CYCLES = redriver_cfg_pkg::PROBE_CYCLES
) (
  input  wire logic       CLK_IN,                      // 200 MHz clock
  input  wire logic       RSTN_IN,                     // async reset, active low
  input  wire logic       CE_IN,                       // clock enable, freezes all
  input  wire logic       SCL_IN,                      // serial clock level
  input  wire logic       SDA_IN,                      // serial data level
  output logic            SDA_OUT,                     // serial data out, always low
  output logic            SDA_OE_OUT,                  // high while pulling SDA low
  input  wire logic       SLAVE_ADDR_BIT0_IN,          // address strap bit 0
  input  wire logic       SLAVE_ADDR_BIT1_IN,          // address strap bit 1
  input  wire logic       SLAVE_ADDR_BIT4_IN,          // address strap bit 4
  input  wire logic       PIN_CONFIG_SEL_IN,           // 1 straps, 0 serial config
  input  wire logic       LOOP_BACK_N_IN,              // loopback strap, active low
  input  wire logic       CARD_PRESENT_N_IN,           // card present, active low
  input  wire logic       GROUP_A_DETECT_RESET_N_IN,   // group A detect reset
  input  wire logic       GROUP_B_DETECT_RESET_N_IN,   // group B detect reset
  input  wire logic       GROUP_A_RX_DETECT_EN_IN,     // group A detect enable strap
  input  wire logic       GROUP_B_RX_DETECT_EN_IN,     // group B detect enable strap
  input  wire logic       BUS_ENABLE_IN,               // 0 enters standby
  output logic            LOOPBACK_OUT,                // A rx drives A and B tx
  output logic            CHANNEL_ENABLE_OUT,          // all channels enabled
  output logic            STANDBY_OUT,                 // low-power standby
  output logic            TERM_ACTIVE_OUT,             // 0: input hi-z, output weak
  output logic            I2C_ENABLED_OUT,             // serial config access open
  output logic [7:0]      CTRL_REG_OUT,                // control register
  output logic [2:0]      EQ_A_OUT,                    // group A equalizer select
  output logic [2:0]      EMPH_A_OUT,                  // group A de-emphasis select
  output logic [1:0]      SWING_A_OUT,                 // group A swing select
  output logic [2:0]      EQ_B_OUT,                    // group B equalizer select
  output logic [2:0]      EMPH_B_OUT,                  // group B de-emphasis select
  output logic [1:0]      SWING_B_OUT,                 // group B swing select
  output logic [1:0]      DETECT_PROBING_OUT,          // per group, bit0 = A
  output logic [1:0]      DETECT_FOUND_OUT             // per group, bit0 = A
);

  typedef struct packed {
    logic                         captured;
    logic [2:0][7:0]              regs;
    redriver_cfg_pkg::i2c_state_t st;
    logic                         scl_q;
    logic                         sda_q;
    logic [2:0]                   cnt;
    logic                         full;
    logic [7:0]                   sh;
    logic                         rw;
    logic                         have_ptr;
    logic [7:0]                   ptr;
    logic                         sda_oe;
    logic                         loopback;
    logic                         chan_en;
    logic                         standby;
    logic                         term_active;
    logic                         i2c_en;
    logic [1:0]                   det_run;
  } state_t;

  state_t     s;
  state_t     next_s;
  logic [6:0] dev_addr;
  logic [7:0] strap_ctrl;
  logic [7:0] rd_data;
  logic       rise;
  logic       fall;
  logic       start_seen;
  logic       stop_seen;
  logic       serial_ok;

  always_comb begin
    dev_addr                = ADDR_BASE;
    dev_addr[redriver_cfg_pkg::ADDR_BIT0_POS] = SLAVE_ADDR_BIT0_IN; // RULE1
    dev_addr[redriver_cfg_pkg::ADDR_BIT1_POS] = SLAVE_ADDR_BIT1_IN; // RULE1
    dev_addr[redriver_cfg_pkg::ADDR_BIT4_POS] = SLAVE_ADDR_BIT4_IN; // RULE1
    strap_ctrl              = 8'h00;
    strap_ctrl[redriver_cfg_pkg::CTRL_LOOP_BACK_N] = LOOP_BACK_N_IN;
    strap_ctrl[redriver_cfg_pkg::CTRL_RESET_A_N]   = GROUP_A_DETECT_RESET_N_IN;
    strap_ctrl[redriver_cfg_pkg::CTRL_RESET_B_N]   = GROUP_B_DETECT_RESET_N_IN;
    strap_ctrl[redriver_cfg_pkg::CTRL_RX_DET_A]    = GROUP_A_RX_DETECT_EN_IN;
    strap_ctrl[redriver_cfg_pkg::CTRL_RX_DET_B]    = GROUP_B_RX_DETECT_EN_IN;
    // unmapped pointers read as zero
    rd_data = (s.ptr < 8'(redriver_cfg_pkg::NUM_REGS)) ? s.regs[s.ptr[1:0]] : 8'h00;
  end

  assign rise       = SCL_IN & ~s.scl_q;
  assign fall       = ~SCL_IN & s.scl_q;
  assign start_seen = s.scl_q & SCL_IN & s.sda_q & ~SDA_IN;
  assign stop_seen  = s.scl_q & SCL_IN & ~s.sda_q & SDA_IN;
  // live level, never latched, so a flip mid-transfer aborts it at once
  assign serial_ok  = ~PIN_CONFIG_SEL_IN; // RULE9

  always_comb begin
    next_s       = s;
    next_s.scl_q = SCL_IN;
    next_s.sda_q = SDA_IN;

    // serial slave
    if (!serial_ok || stop_seen) begin // RULE5
      next_s.st     = redriver_cfg_pkg::I2C_IDLE;
      next_s.sda_oe = 1'b0;
      next_s.full   = 1'b0;
    end else if (start_seen) begin
      next_s.st       = redriver_cfg_pkg::I2C_ADDR;
      next_s.cnt      = 3'h0;
      next_s.full     = 1'b0;
      next_s.have_ptr = 1'b0;
      next_s.sda_oe   = 1'b0;
    end else begin
      case (s.st)
        redriver_cfg_pkg::I2C_IDLE: begin
          next_s.sda_oe = 1'b0;
        end
        redriver_cfg_pkg::I2C_ADDR, redriver_cfg_pkg::I2C_RX: begin
          if (rise) begin
            next_s.sh  = {s.sh[6:0], SDA_IN};
            next_s.cnt = s.cnt + 3'h1;
            if (s.cnt == 3'h7) begin
              next_s.full = 1'b1;
            end
          end else if (fall && s.full) begin
            next_s.full = 1'b0;
            if (s.st == redriver_cfg_pkg::I2C_ADDR) begin
              if (s.sh[7:1] == dev_addr) begin // RULE1
                next_s.rw     = s.sh[0];
                next_s.sda_oe = 1'b1;
                next_s.st     = redriver_cfg_pkg::I2C_ACK;
              end else begin
                next_s.st = redriver_cfg_pkg::I2C_IDLE;
              end
            end else begin
              if (!s.have_ptr) begin
                next_s.ptr      = s.sh;
                next_s.have_ptr = 1'b1;
              end else begin
                next_s.ptr = s.ptr + 8'h01;
              end
              next_s.sda_oe = 1'b1;
              next_s.st     = redriver_cfg_pkg::I2C_ACK;
            end
          end
        end
        redriver_cfg_pkg::I2C_ACK: begin
          if (fall) begin
            next_s.cnt = 3'h0;
            if (s.rw) begin
              next_s.sh     = rd_data;
              next_s.sda_oe = ~rd_data[7];
              next_s.ptr    = s.ptr + 8'h01;
              next_s.st     = redriver_cfg_pkg::I2C_TX;
            end else begin
              next_s.sda_oe = 1'b0;
              next_s.st     = redriver_cfg_pkg::I2C_RX;
            end
          end
        end
        redriver_cfg_pkg::I2C_TX: begin
          if (fall) begin
            if (s.cnt == 3'h7) begin
              next_s.sda_oe = 1'b0;
              next_s.full   = 1'b0;
              next_s.st     = redriver_cfg_pkg::I2C_MACK;
            end else begin
              next_s.cnt    = s.cnt + 3'h1;
              next_s.sh     = {s.sh[6:0], 1'b0};
              next_s.sda_oe = ~s.sh[6];
            end
          end
        end
        redriver_cfg_pkg::I2C_MACK: begin
          if (rise) begin
            next_s.full = ~SDA_IN;
          end else if (fall) begin
            next_s.full = 1'b0;
            if (s.full) begin
              next_s.cnt    = 3'h0;
              next_s.sh     = rd_data;
              next_s.sda_oe = ~rd_data[7];
              next_s.ptr    = s.ptr + 8'h01;
              next_s.st     = redriver_cfg_pkg::I2C_TX;
            end else begin
              next_s.st = redriver_cfg_pkg::I2C_IDLE;
            end
          end
        end
        default: begin
          next_s.st     = redriver_cfg_pkg::I2C_IDLE;
          next_s.sda_oe = 1'b0;
        end
      endcase
    end

    // configuration registers; straps load the control register at startup and while selected
    if (!s.captured || PIN_CONFIG_SEL_IN) begin // RULE6 RULE5
      next_s.regs[redriver_cfg_pkg::REG_CTRL[1:0]] = strap_ctrl;
      next_s.captured                            = 1'b1;
    end else if (s.st == redriver_cfg_pkg::I2C_RX && fall && s.full && s.have_ptr &&
                 serial_ok && s.ptr < 8'(redriver_cfg_pkg::NUM_REGS)) begin // RULE4 RULE12
      next_s.regs[s.ptr[1:0]] = s.sh;
    end

    // control outputs follow one cycle later: loopback from the registers, detect run from the registers and pins, the rest from pins
    next_s.loopback    = ~s.regs[redriver_cfg_pkg::REG_CTRL[1:0]]
                           [redriver_cfg_pkg::CTRL_LOOP_BACK_N]; // RULE2 RULE3
    next_s.chan_en     = ~CARD_PRESENT_N_IN & BUS_ENABLE_IN; // RULE7
    next_s.standby     = ~BUS_ENABLE_IN; // RULE8
    next_s.term_active = ~CARD_PRESENT_N_IN; // RULE11
    next_s.i2c_en      = serial_ok; // RULE9
    next_s.det_run[0]  = ~CARD_PRESENT_N_IN & BUS_ENABLE_IN &
                         s.regs[redriver_cfg_pkg::REG_CTRL[1:0]]
                           [redriver_cfg_pkg::CTRL_RX_DET_A]; // RULE11
    next_s.det_run[1]  = ~CARD_PRESENT_N_IN & BUS_ENABLE_IN &
                         s.regs[redriver_cfg_pkg::REG_CTRL[1:0]]
                           [redriver_cfg_pkg::CTRL_RX_DET_B]; // RULE11
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      s          <= '0;
      s.regs[0]  <= redriver_cfg_pkg::CTRL_RESET;
      s.regs[1]  <= redriver_cfg_pkg::GROUP_RESET;
      s.regs[2]  <= redriver_cfg_pkg::GROUP_RESET;
      s.scl_q    <= 1'b1;
      s.sda_q    <= 1'b1;
      s.i2c_en   <= 1'b0;
      s.standby  <= 1'b1;
    end else if (CE_IN) begin
      s <= next_s;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : grp
    redriver_rx_detect #(
      .PROBE_CYCLES (PROBE_CYCLES)
    ) u_det (
      .clk         (CLK_IN),
      .rst_n       (RSTN_IN),
      .ce          (CE_IN),
      .run         (s.det_run[g]),
      .det_reset_n (s.regs[0][redriver_cfg_pkg::CTRL_RESET_A_N + g]), // RULE10
      .probing     (DETECT_PROBING_OUT[g]),
      .found       (DETECT_FOUND_OUT[g])
    );
  end

  assign SDA_OUT            = 1'b0;
  assign SDA_OE_OUT         = s.sda_oe;
  assign LOOPBACK_OUT       = s.loopback;
  assign CHANNEL_ENABLE_OUT = s.chan_en;
  assign STANDBY_OUT        = s.standby;
  assign TERM_ACTIVE_OUT    = s.term_active;
  assign I2C_ENABLED_OUT    = s.i2c_en;
  assign CTRL_REG_OUT       = s.regs[0];
  assign EQ_A_OUT    = s.regs[1][redriver_cfg_pkg::GRP_EQ_LSB +: 3];
  assign EMPH_A_OUT  = s.regs[1][redriver_cfg_pkg::GRP_EMPH_LSB +: 3];
  assign SWING_A_OUT = s.regs[1][redriver_cfg_pkg::GRP_SWING_LSB +: 2];
  assign EQ_B_OUT    = s.regs[2][redriver_cfg_pkg::GRP_EQ_LSB +: 3];
  assign EMPH_B_OUT  = s.regs[2][redriver_cfg_pkg::GRP_EMPH_LSB +: 3];
  assign SWING_B_OUT = s.regs[2][redriver_cfg_pkg::GRP_SWING_LSB +: 2];

endmodule

// [design/redriver_cfg_pkg.sv]
// shared constants and types of the re-driver configuration and control block
// assumes one 200 MHz clock and pins already synchronous to it
package redriver_cfg_pkg;

  localparam int CLK_PERIOD_NS = 5;

  // configuration register indices, reached through the serial pointer byte
  localparam int         NUM_REGS    = 3;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_GROUP_A = 8'h01;
  localparam logic [7:0] REG_GROUP_B = 8'h02;

  // control register fields
  localparam int CTRL_LOOP_BACK_N = 0;
  localparam int CTRL_RESET_A_N   = 1;
  localparam int CTRL_RESET_B_N   = 2;
  localparam int CTRL_RX_DET_A    = 3;
  localparam int CTRL_RX_DET_B    = 4;

  // group register fields
  localparam int GRP_EQ_LSB    = 0;
  localparam int GRP_EMPH_LSB  = 3;
  localparam int GRP_SWING_LSB = 6;

  // reset values; all strap inputs have pull-ups
  localparam logic [7:0] CTRL_RESET  = 8'h1f;
  localparam logic [7:0] GROUP_RESET = 8'h00;

  // slave address: fixed part plus three strapped bits
  localparam logic [6:0] ADDR_BASE     = 7'h70;
  localparam int         ADDR_BIT0_POS = 0;
  localparam int         ADDR_BIT1_POS = 1;
  localparam int         ADDR_BIT4_POS = 4;

  // least time a receiver probe lasts, rounded up to whole cycles
  localparam int PROBE_TIME_NS = 500;
  localparam int PROBE_CYCLES  = (PROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_ACK  = 3'b010,
    I2C_RX   = 3'b011,
    I2C_TX   = 3'b100,
    I2C_MACK = 3'b101
  } i2c_state_t;

  typedef enum logic [1:0] {
    DET_OFF   = 2'b00,
    DET_PROBE = 2'b01,
    DET_DONE  = 2'b10
  } det_state_t;

endpackage

// [design/redriver_rx_detect.sv]
// receiver detect sequencer for one group of four channels
// assumes run and det_reset_n are synchronous to clk
`timescale 1ns/10ps
module redriver_rx_detect #(
  parameter int PROBE_CYCLES = redriver_cfg_pkg::PROBE_CYCLES
) (
  input  wire logic clk,          // block clock
  input  wire logic rst_n,        // async reset, active low
  input  wire logic ce,           // clock enable
  input  wire logic run,          // card present, detect enabled, not standby
  input  wire logic det_reset_n,  // group detect reset, active low
  output logic      probing,      // probe in progress
  output logic      found         // probe complete, receiver seen
);

  typedef struct packed {
    redriver_cfg_pkg::det_state_t st;
    logic [15:0]                  cnt;
  } det_t;

  det_t s;
  det_t next_s;

  always_comb begin
    next_s = s;
    if (!run || !det_reset_n) begin // RULE10 RULE11
      next_s.st  = redriver_cfg_pkg::DET_OFF;
      next_s.cnt = 16'h0000;
    end else begin
      case (s.st)
        redriver_cfg_pkg::DET_OFF: begin
          next_s.st  = redriver_cfg_pkg::DET_PROBE;
          next_s.cnt = 16'h0000;
        end
        redriver_cfg_pkg::DET_PROBE: begin
          if (s.cnt == 16'(PROBE_CYCLES - 1)) begin
            next_s.st = redriver_cfg_pkg::DET_DONE;
          end else begin
            next_s.cnt = s.cnt + 16'h0001;
          end
        end
        redriver_cfg_pkg::DET_DONE: begin
          next_s.st = redriver_cfg_pkg::DET_DONE;
        end
        default: begin
          next_s.st = redriver_cfg_pkg::DET_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{st: redriver_cfg_pkg::DET_OFF, cnt: 16'h0000};
    end else if (ce) begin
      s <= next_s;
    end
  end

  // probe and done codes each own one state bit, so both outputs are plain flops
  assign probing = s.st[0];
  assign found   = s.st[1];

endmodule

// [verif/i2c_host_model.sv]
// serial host model: drives the clock line and an open-drain data line
// assumes the device's data enable is registered and CLK_IN paces each phase
`timescale 1ns/10ps
module i2c_host_model (
  input  wire logic clk,    // pacing clock
  input  wire logic sda_oe, // device pulls data low
  output logic      scl,    // serial clock level
  output logic      sda     // resolved data level
);
  logic drv = 1'b1;
  // released wire reads high through the pull-up, never the last driven value
  assign sda = drv & ~sda_oe;
  initial scl = 1'b1;
  // four clocks per phase stays above the device's one-sample minimum
  task automatic wt();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic start();
    drv = 1'b1;
    wt();
    scl = 1'b1;
    wt();
    drv = 1'b0;
    wt();
    scl = 1'b0;
    wt();
  endtask
  task automatic stop();
    drv = 1'b0;
    wt();
    scl = 1'b1;
    wt();
    drv = 1'b1;
    wt();
  endtask
  task automatic xfer(input logic b, output logic r);
    drv = b;
    wt();
    scl = 1'b1;
    wt();
    r = sda;
    scl = 1'b0;
    wt();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer(d[i], r);
    xfer(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer(1'b1, d[i]);
    xfer(last, r);
  endtask
endmodule

// [verif/redriver_config_control_chk.sv]
// assertions on the re-driver control block, seen from its top ports
// assumes one clock domain; the block advances only while CE_IN is high
`timescale 1ns/10ps
module redriver_config_control_chk (
  input wire logic       CLK_IN,                    // clock
  input wire logic       RSTN_IN,                   // reset, active low
  input wire logic       CE_IN,                     // clock enable
  input wire logic       PIN_CONFIG_SEL_IN,         // strap select
  input wire logic       LOOP_BACK_N_IN,            // loopback strap
  input wire logic       CARD_PRESENT_N_IN,         // card present
  input wire logic       GROUP_A_DETECT_RESET_N_IN, // reset strap a
  input wire logic       GROUP_B_DETECT_RESET_N_IN, // reset strap b
  input wire logic       GROUP_A_RX_DETECT_EN_IN,   // detect strap a
  input wire logic       GROUP_B_RX_DETECT_EN_IN,   // detect strap b
  input wire logic       BUS_ENABLE_IN,             // bus enable
  input wire logic       SDA_OE_OUT,                // data pull-down
  input wire logic       LOOPBACK_OUT,              // loopback
  input wire logic       CHANNEL_ENABLE_OUT,        // channels on
  input wire logic       STANDBY_OUT,               // standby
  input wire logic       TERM_ACTIVE_OUT,           // termination
  input wire logic       I2C_ENABLED_OUT,           // serial open
  input wire logic [7:0] CTRL_REG_OUT,              // control reg
  input wire logic [2:0] EQ_A_OUT,                  // eq a
  input wire logic [2:0] EQ_B_OUT,                  // eq b
  input wire logic [1:0] DETECT_PROBING_OUT,        // probing
  input wire logic [1:0] DETECT_FOUND_OUT           // found
);
  wire logic [4:0] straps = {GROUP_B_RX_DETECT_EN_IN, GROUP_A_RX_DETECT_EN_IN,
                             GROUP_B_DETECT_RESET_N_IN, GROUP_A_DETECT_RESET_N_IN, LOOP_BACK_N_IN};
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  a_standby_entry: assert property (
    CE_IN && !BUS_ENABLE_IN |=> STANDBY_OUT && !CHANNEL_ENABLE_OUT) else $error("no standby");
  a_channels_on: assert property (
    CE_IN && $past(RSTN_IN) && !CARD_PRESENT_N_IN && BUS_ENABLE_IN
    |=> CHANNEL_ENABLE_OUT && TERM_ACTIVE_OUT) else $error("channels not enabled");
  a_term_weak: assert property (
    (CE_IN && CARD_PRESENT_N_IN)[*2] |=> !TERM_ACTIVE_OUT && DETECT_PROBING_OUT == 2'b00
    && DETECT_FOUND_OUT == 2'b00) else $error("detect active without card");
  a_serial_gate: assert property (
    CE_IN && $past(RSTN_IN) |=> I2C_ENABLED_OUT == !$past(PIN_CONFIG_SEL_IN))
    else $error("serial enable wrong");
  a_strap_no_ack: assert property (
    (CE_IN && PIN_CONFIG_SEL_IN)[*2] |=> !SDA_OE_OUT) else $error("data driven in strap mode");
  a_ctrl_strap: assert property (
    (CE_IN && PIN_CONFIG_SEL_IN)[*2] |=> CTRL_REG_OUT[4:0] == $past(straps))
    else $error("control not following straps");
  a_loop_path: assert property (
    (CE_IN && PIN_CONFIG_SEL_IN)[*3] |=> LOOPBACK_OUT == !$past(LOOP_BACK_N_IN, 2))
    else $error("loopback wrong");
  a_group_hold: assert property (
    PIN_CONFIG_SEL_IN && $past(PIN_CONFIG_SEL_IN) |=> $stable({EQ_A_OUT, EQ_B_OUT}))
    else $error("group register changed in strap mode");
  a_detect_reset: assert property (
    (CE_IN && PIN_CONFIG_SEL_IN && !GROUP_A_DETECT_RESET_N_IN)[*2]
    |=> !DETECT_PROBING_OUT[0] && !DETECT_FOUND_OUT[0]) else $error("detect not reset");
endmodule
bind redriver_config_control redriver_config_control_chk i_redriver_config_control_chk (.*);

// [verif/test_redriver_config_control.sv]
// self-checking bench for the re-driver control block with a serial host model
// assumes the design package and the checker are compiled before this file
`timescale 1ns/10ps
module test_redriver_config_control;
  logic CLK_IN = 1'b0, RSTN_IN = 1'b0, CE_IN = 1'b1, PIN_CONFIG_SEL_IN = 1'b0;
  logic SLAVE_ADDR_BIT0_IN = 1'b1, SLAVE_ADDR_BIT1_IN = 1'b1, SLAVE_ADDR_BIT4_IN = 1'b0;
  logic LOOP_BACK_N_IN = 1'b0, CARD_PRESENT_N_IN = 1'b0, BUS_ENABLE_IN = 1'b1;
  logic GROUP_A_DETECT_RESET_N_IN = 1'b1, GROUP_B_DETECT_RESET_N_IN = 1'b0;
  logic GROUP_A_RX_DETECT_EN_IN = 1'b1, GROUP_B_RX_DETECT_EN_IN = 1'b0;
  wire logic SCL_IN, SDA_IN, SDA_OUT, SDA_OE_OUT, LOOPBACK_OUT, CHANNEL_ENABLE_OUT;
  wire logic STANDBY_OUT, TERM_ACTIVE_OUT, I2C_ENABLED_OUT;
  wire logic [7:0] CTRL_REG_OUT;
  wire logic [2:0] EQ_A_OUT, EMPH_A_OUT, EQ_B_OUT, EMPH_B_OUT;
  wire logic [1:0] SWING_A_OUT, SWING_B_OUT, DETECT_PROBING_OUT, DETECT_FOUND_OUT;
  int fails = 0;
  int compares = 0;
  // straps set bits 0 and 1 and clear bit 4 of the fixed base
  localparam logic [6:0] ADDR = (redriver_cfg_pkg::ADDR_BASE & 7'h6c) | 7'h03;
  redriver_config_control #(.PROBE_CYCLES(4)) i_redriver_config_control (.*);
  i2c_host_model i_i2c_host_model (.clk(CLK_IN), .sda_oe(SDA_OE_OUT), .scl(SCL_IN),
                                   .sda(SDA_IN));
  initial forever #2.5 CLK_IN = ~CLK_IN;
  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wcyc(input int n);
    repeat (n) @(posedge CLK_IN);
    #1;
  endtask
  task automatic wfound(input logic [1:0] exp);
    int i;
    for (i = 0; i < 200 && DETECT_FOUND_OUT !== exp; i++)
      wcyc(1);
    chk("found", {6'h0, exp}, {6'h0, DETECT_FOUND_OUT});
    if (i == 200)
      summarize();
  endtask
  // every byte of the transfer must be answered alike: all acked or none
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                    input int n, input logic ok);
    logic k;
    i_i2c_host_model.start();
    i_i2c_host_model.wbyte({a, 1'b0}, k);
    chk("ack", {7'h0, ok}, {7'h0, k});
    i_i2c_host_model.wbyte(p, k);
    chk("ack", {7'h0, ok}, {7'h0, k});
    for (int i = 0; i < n; i++) begin
      i_i2c_host_model.wbyte(d[15:8], k);
      chk("ack", {7'h0, ok}, {7'h0, k});
      d = d << 8;
    end
    i_i2c_host_model.stop();
    wcyc(2);
  endtask
  task automatic t_startup();
    chk("ctrl", 8'h0a, {3'h0, CTRL_REG_OUT[4:0]});
    LOOP_BACK_N_IN = 1'b1;
    wcyc(3);
    chk("ctrl", 8'h0a, {3'h0, CTRL_REG_OUT[4:0]});
    chk("loopback", 8'h01, {7'h0, LOOPBACK_OUT});
  endtask
  task automatic t_write();
    logic [7:0] v;
    logic k;
    wr(ADDR ^ 7'h10, 8'h00, 16'h1f00, 1, 1'b0);
    chk("ctrl", 8'h0a, {3'h0, CTRL_REG_OUT[4:0]});
    SLAVE_ADDR_BIT1_IN = 1'b0;
    wr(ADDR ^ 7'h02, 8'h00, 16'h1e00, 1, 1'b1);
    chk("ctrl", 8'h1e, CTRL_REG_OUT);
    SLAVE_ADDR_BIT1_IN = 1'b1;
    wr(ADDR, 8'h00, 16'h1f00, 1, 1'b1);
    chk("loopback", 8'h00, {7'h0, LOOPBACK_OUT});
    wr(ADDR, 8'h00, 16'h1e00, 1, 1'b1);
    chk("loopback", 8'h01, {7'h0, LOOPBACK_OUT});
    wr(ADDR, 8'h01, 16'ha53c, 2, 1'b1);
    chk("group a", 8'ha5, {SWING_A_OUT, EMPH_A_OUT, EQ_A_OUT});
    chk("group b", 8'h3c, {SWING_B_OUT, EMPH_B_OUT, EQ_B_OUT});
    i_i2c_host_model.start();
    i_i2c_host_model.wbyte({ADDR, 1'b0}, k);
    i_i2c_host_model.wbyte(8'h01, k);
    i_i2c_host_model.start();
    i_i2c_host_model.wbyte({ADDR, 1'b1}, k);
    chk("read ack", 8'h01, {7'h0, k});
    i_i2c_host_model.rbyte(1'b0, v);
    chk("read a", 8'ha5, v);
    i_i2c_host_model.rbyte(1'b1, v);
    chk("read b", 8'h3c, v);
    chk("sda out", 8'h00, {7'h0, SDA_OUT});
    i_i2c_host_model.stop();
  endtask
  task automatic t_strap();
    PIN_CONFIG_SEL_IN = 1'b1;
    LOOP_BACK_N_IN = 1'b0;
    wcyc(3);
    chk("serial on", 8'h00, {7'h0, I2C_ENABLED_OUT});
    chk("ctrl", 8'h0a, {3'h0, CTRL_REG_OUT[4:0]});
    wr(ADDR, 8'h01, 16'h0000, 1, 1'b0);
    chk("group a", 8'ha5, {SWING_A_OUT, EMPH_A_OUT, EQ_A_OUT});
    PIN_CONFIG_SEL_IN = 1'b0;
    wcyc(2);
    chk("serial on", 8'h01, {7'h0, I2C_ENABLED_OUT});
    wr(ADDR, 8'h01, 16'h0700, 1, 1'b1);
    chk("group a", 8'h07, {SWING_A_OUT, EMPH_A_OUT, EQ_A_OUT});
  endtask
  task automatic t_pins();
    // a low clock enable must hold channel enable and termination while card present moves
    CE_IN = 1'b0;
    CARD_PRESENT_N_IN = 1'b1;
    wcyc(2);
    chk("frozen", 8'h03, {6'h0, CHANNEL_ENABLE_OUT, TERM_ACTIVE_OUT});
    CE_IN = 1'b1;
    wcyc(2);
    chk("chan term", 8'h00, {6'h0, CHANNEL_ENABLE_OUT, TERM_ACTIVE_OUT});
    CARD_PRESENT_N_IN = 1'b0;
    wcyc(2);
    chk("chan term", 8'h03, {6'h0, CHANNEL_ENABLE_OUT, TERM_ACTIVE_OUT});
    BUS_ENABLE_IN = 1'b0;
    wcyc(2);
    chk("chan standby", 8'h01, {6'h0, CHANNEL_ENABLE_OUT, STANDBY_OUT});
    BUS_ENABLE_IN = 1'b1;
    wcyc(2);
    chk("chan standby", 8'h02, {6'h0, CHANNEL_ENABLE_OUT, STANDBY_OUT});
  endtask
  task automatic t_detect();
    wr(ADDR, 8'h00, 16'h1b00, 1, 1'b1);
    wfound(2'b01);
    wr(ADDR, 8'h00, 16'h1f00, 1, 1'b1);
    wfound(2'b11);
    PIN_CONFIG_SEL_IN = 1'b1;
    GROUP_A_DETECT_RESET_N_IN = 1'b0;
    GROUP_B_DETECT_RESET_N_IN = 1'b1;
    GROUP_B_RX_DETECT_EN_IN = 1'b1;
    wfound(2'b10);
    GROUP_A_DETECT_RESET_N_IN = 1'b1;
    wcyc(2);
    chk("probing", 8'h01, {6'h0, DETECT_PROBING_OUT});
    wfound(2'b11);
    CARD_PRESENT_N_IN = 1'b1;
    wfound(2'b00);
  endtask
  initial begin
    wcyc(2);
    RSTN_IN = 1'b1;
    wcyc(3);
    t_startup();
    t_write();
    t_strap();
    t_pins();
    t_detect();
    summarize();
  end
endmodule
